/* logic/led_display_consts.svh */
/*
  Constants of the eight-digit LED display write port: control-word field
  positions, reset value, scan timing and buffer sizing.
  Assumes a core clock of 20 MHz; included by bare name.
*/
`ifndef LED_DISPLAY_CONSTS_SVH
`define LED_DISPLAY_CONSTS_SVH

// Core clock and scan timing
`define CLK_HZ 20000000
`define SCAN_RATE_HZ 390
`define DIGIT_COUNT 8
`define SLOT_CYCLES (`CLK_HZ / (`SCAN_RATE_HZ * `DIGIT_COUNT))
`define BLANK_TIME_NS 10000
`define BLANK_MIN_NS 2000
`define BLANK_CYCLES ((`BLANK_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)

// Control word field positions
`define CTRL_BURST_BIT 7
`define CTRL_FONT_BIT 6
`define CTRL_BYPASS_BIT 5
`define CTRL_POWER_BIT 4
`define CTRL_BANK_BIT 3
`define CTRL_ADDR_MSB 2
`define CTRL_ADDR_LSB 0
`define CTRL_RESET 8'h10

// Digit word layout
`define WORD_DP_BIT 7

// Write buffer
`define FIFO_DEPTH 16
`define FIFO_WIDTH 9
`define BURST_LEN 4'h8

`endif

/* logic/led_display_pkg.sv */
/*
  Types of the LED display write port: control word layout and the
  display RAM update sequencer states.
  Assumes the constants header supplies field positions and values.
*/
package led_display_pkg;

  typedef logic [7:0] digit_word_t;

  // Bit order matches the control byte, so a byte casts straight in
  typedef struct packed {
    logic burst;
    logic font_hex;
    logic bypass;
    logic normal;
    logic bank_a;
    logic [2:0] addr;
  } ctrl_s;

  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_SINGLE = 2'b01,
    UPD_BURST = 2'b10
  } update_e;

endpackage

/* logic/led_display_write_port.sv */
/*
  Write port, control decode, display RAM and scan of an eight-digit
  seven-segment multiplexed LED driver, plus its write buffer FIFO.
  Assumes asynchronous pins from a microprocessor, active-high LED drives
  and a single 20 MHz core clock.
*/
//
// Behaviour
// - Capture input bus at write strobe rising edge
// - Select high loads control, low loads RAM
// - Lines 0-7 form bits 0-7, top is DP
// - Control bit 6 picks hex or BCD font
// - Control bit 5 high bypasses font decode
// - Control bit 7 high announces sequential burst
// - Control bit 4 low shuts oscillator and display
// - Bits 2..0 give single-digit target address
// - Control bit 3 picks bank A or B; no-decode always uses bank A
// - Eight segment lines and eight digit drives
// - Each digit refreshed near 390 Hz
// - Blank digits between slots, no overlap
`timescale 1ns/1ns
`include "led_display_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module write_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  input wire logic in_valid, // Push request
  output logic in_ready, // Room for a push
  input wire logic [WIDTH-1:0] in_data, // Pushed word
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain takes the word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } fifo_s;

  fifo_s st_q;
  fifo_s st_d;
  logic push;
  logic pop;

  // Flags come straight from the occupancy count
  assign in_ready = (st_q.count != (AW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign out_data = st_q.mem[st_q.rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer wrap relies on DEPTH being a power of two
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wptr] = in_data;
      st_d.wptr = st_q.wptr + 1'b1;
    end
    if (pop) begin
      st_d.rptr = st_q.rptr + 1'b1;
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module led_display_write_port #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES,
  parameter int BLANK_CYCLES = `BLANK_CYCLES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic resetn, // Async reset, active low
  input wire logic write_strobe, // Write pin, stores on rise
  input wire logic mode_select, // High control word, low RAM
  input wire logic [7:0] input_bus, // Input lines 0 to 7
  output logic [6:0] led_bar_lines, // Segments a..g, active high
  output logic decimal_point_drive, // Decimal point, active high
  output logic [7:0] digit_drive, // Digit commons, active high
  output logic write_ready // Buffer has room for a write
);
  localparam int PRE_W = $clog2(SLOT_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SLOT_CYCLES - 1);
  localparam logic [PRE_W-1:0] BLANK_END = PRE_W'(BLANK_CYCLES);
  localparam logic BANK_A = 1'b1;

  // Glyphs as {g,f,e,d,c,b,a}, entry 15 first
  localparam logic [15:0][6:0] HEX_FONT = {
    7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C, 7'h77, 7'h6F, 7'h7F,
    7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};
  localparam logic [15:0][6:0] BCD_FONT = {
    7'h00, 7'h73, 7'h38, 7'h76, 7'h79, 7'h40, 7'h6F, 7'h7F,
    7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};

  typedef struct packed {
    logic [2:0] wr_s;
    logic [1:0] mode_s;
    logic [1:0][7:0] bus_s;
    led_display_pkg::ctrl_s ctrl;
    led_display_pkg::update_e upd;
    logic [3:0] burst_left;
    logic [1:0][7:0][7:0] ram;
    logic [PRE_W-1:0] pre;
    logic [2:0] scan;
    logic [6:0] seg;
    logic dp;
    logic [7:0] dig;
    logic ready;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic wr_evt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic drain_ok;
  logic pop;
  logic pop_ctrl;
  logic [7:0] pop_byte;
  logic wr_bank;
  logic blank;

  // Font lookup: bypass passes RAM bits, else a nibble picks a glyph
  function automatic logic [6:0] glyph(input logic [7:0] word, input logic hex,
                                       input logic bypass);
    logic [6:0] g;
    g = hex ? HEX_FONT[word[3:0]] : BCD_FONT[word[3:0]];
    glyph = bypass ? word[6:0] : g;
  endfunction

  // Rising edge of the synchronised strobe; stage 0 feeds stage 1 only
  assign wr_evt = st_q.wr_s[1] & ~st_q.wr_s[2];
  assign blank = (st_q.pre < BLANK_END);
  // Writes apply only while digits are dark, so no digit shows a torn word
  assign drain_ok = blank | ~st_q.ctrl.normal;
  assign pop = fifo_out_valid & drain_ok;
  assign pop_ctrl = fifo_out_data[8];
  assign pop_byte = fifo_out_data[7:0];
  // No-decode always uses bank A; decode modes honour the bank bit
  assign wr_bank = st_q.ctrl.bypass ? BANK_A : st_q.ctrl.bank_a;

  // Buffer between the pin capture and the RAM/control update
  write_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .resetn(resetn),
    .in_valid(wr_evt),
    .in_ready(fifo_in_ready),
    .in_data({st_q.mode_s[1], st_q.bus_s[1]}),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ok),
    .out_data(fifo_out_data)
  );

  // Next-state logic: sync, update sequencer, scan and output drives
  always_comb begin
    st_d = st_q;
    st_d.wr_s = {st_q.wr_s[1:0], write_strobe};
    st_d.mode_s = {st_q.mode_s[0], mode_select};
    st_d.bus_s = {st_q.bus_s[0], input_bus};
    st_d.ready = fifo_in_ready;
    if (pop && pop_ctrl) begin
      st_d.ctrl = led_display_pkg::ctrl_s'(pop_byte);
      if (pop_byte[`CTRL_BURST_BIT]) begin
        st_d.upd = led_display_pkg::UPD_BURST;
        st_d.burst_left = `BURST_LEN;
      end else begin
        st_d.upd = led_display_pkg::UPD_SINGLE;
      end
    end else if (pop) begin
      unique case (st_q.upd)
        led_display_pkg::UPD_IDLE: begin
          st_d.upd = led_display_pkg::UPD_IDLE;
        end
        led_display_pkg::UPD_SINGLE: begin
          st_d.ram[wr_bank][st_q.ctrl.addr] = pop_byte;
          st_d.upd = led_display_pkg::UPD_IDLE;
        end
        led_display_pkg::UPD_BURST: begin
          st_d.ram[wr_bank][3'(`BURST_LEN - st_q.burst_left)] = pop_byte;
          st_d.burst_left = st_q.burst_left - 4'h1;
          if (st_q.burst_left == 4'h1) begin
            st_d.upd = led_display_pkg::UPD_IDLE;
          end
        end
        default: begin
          st_d.upd = led_display_pkg::UPD_IDLE;
        end
      endcase
    end
    // Scan oscillator stops in shutdown and restarts at the start of the held digit's slot, blanking first
    if (st_q.ctrl.normal) begin
      if (st_q.pre == PRE_LAST) begin
        st_d.pre = '0;
        st_d.scan = st_q.scan + 3'h1;
      end else begin
        st_d.pre = st_q.pre + 1'b1;
      end
    end else begin
      st_d.pre = '0;
    end
    st_d.seg = glyph(st_q.ram[st_q.ctrl.bypass ? BANK_A : st_q.ctrl.bank_a][st_q.scan],
                     st_q.ctrl.font_hex, st_q.ctrl.bypass);
    st_d.dp = st_q.ram[st_q.ctrl.bypass ? BANK_A : st_q.ctrl.bank_a][st_q.scan][`WORD_DP_BIT];
    if (st_q.ctrl.normal && !blank) begin
      st_d.dig = 8'(8'h01 << st_q.scan);
    end else begin
      st_d.dig = 8'h00;
    end
    if (!st_q.ctrl.normal) begin
      st_d.seg = 7'h00;
      st_d.dp = 1'b0;
    end
  end

  // State register; control word resets to normal, decode, BCD font
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.ctrl <= led_display_pkg::ctrl_s'(`CTRL_RESET);
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state register
  assign led_bar_lines = st_q.seg;
  assign decimal_point_drive = st_q.dp;
  assign digit_drive = st_q.dig;
  assign write_ready = st_q.ready;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the capture, the sequencer and the scan
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic [7:0] dark_run;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dark_run <= 8'h00;
    end else if (st_q.dig == 8'h00) begin
      dark_run <= (dark_run == 8'hFF) ? dark_run : dark_run + 8'h01;
    end else begin
      dark_run <= 8'h00;
    end
  end

  property p_capture;
    wr_evt && fifo_in_ready |=> u_fifo.st_q.count == $past(u_fifo.st_q.count) + 5'(!$past(pop));
  endproperty
  a_capture: assert property (p_capture) else $error("write edge not buffered");

  property p_ctrl_load;
    pop && pop_ctrl |=> st_q.ctrl == $past(pop_byte) && $stable(st_q.ram);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control write wrong");

  property p_font;
    pop && pop_ctrl |=> st_q.ctrl.font_hex == $past(pop_byte[6]) &&
      st_q.ctrl.bypass == $past(pop_byte[5]) && st_q.ctrl.bank_a == $past(pop_byte[3]);
  endproperty
  a_font: assert property (p_font) else $error("mode bits misplaced");

  property p_burst_start;
    pop && pop_ctrl && pop_byte[7] |=> st_q.upd == led_display_pkg::UPD_BURST &&
      st_q.burst_left == 4'h8;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst not armed");

  property p_burst_step;
    pop && !pop_ctrl && st_q.upd == led_display_pkg::UPD_BURST |=>
      st_q.burst_left == $past(st_q.burst_left) - 4'h1 &&
      st_q.ram[$past(wr_bank)][3'(8 - $past(st_q.burst_left))] == $past(pop_byte);
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst order wrong");

  property p_single;
    pop && !pop_ctrl && st_q.upd == led_display_pkg::UPD_SINGLE |=>
      st_q.ram[$past(wr_bank)][$past(st_q.ctrl.addr)] == $past(pop_byte) &&
      st_q.upd == led_display_pkg::UPD_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single write misplaced");

  property p_addr;
    pop && pop_ctrl && !pop_byte[7] |=> st_q.ctrl.addr == $past(pop_byte[2:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("digit address wrong");

  property p_shutdown;
    !st_q.ctrl.normal |=> digit_drive == 8'h00 && led_bar_lines == 7'h00;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("display lit in shutdown");

  property p_onehot;
    $onehot0(digit_drive);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two digits driven");

  property p_no_overlap;
    $past(digit_drive) == 8'h00 && digit_drive != 8'h00 && $past(st_q.ctrl.normal) &&
      st_q.ctrl.normal |-> $past(dark_run) >= 8'(BLANK_CYCLES - 1);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("blanking too short");

  property p_slot_hold;
    digit_drive != 8'h00 && $past(digit_drive) != 8'h00 |-> $stable(digit_drive);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("digits switched unblanked");

  c_burst_done: cover property (pop && st_q.upd == led_display_pkg::UPD_BURST &&
                                st_q.burst_left == 4'h1);
  c_single: cover property (pop && !pop_ctrl && st_q.upd == led_display_pkg::UPD_SINGLE);
  c_shutdown: cover property (pop && pop_ctrl && !pop_byte[4]);
  c_full: cover property (!fifo_in_ready);
endmodule

/* testbench/led_host_model.sv */
/*
  Host model: a microprocessor writing control words and display bytes.
  Assumes the port synchronises its pins to core_clk; drives after edges.
*/
`timescale 1ns/1ns
module led_host_model (
  input wire logic core_clk, // Core clock
  output logic write_strobe, // Write pin
  output logic mode_select, // Control or RAM select
  output logic [7:0] input_bus // Input lines
);
  initial begin
    write_strobe = 1'b0;
    mode_select = 1'b0;
    input_bus = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // One write; gap adds setup cycles for a slow host
  task automatic put(input logic m, input logic [7:0] d, input int gap);
    @(posedge core_clk);
    mode_select <= m;
    input_bus <= d;
    write_strobe <= 1'b0;
    repeat (3 + gap) @(posedge core_clk);
    write_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Scrambled after hold, so stale data never passes as valid
    input_bus <= ~d;
  endtask
endmodule

/* testbench/led_display_write_port_test.sv */
/*
  Self-checking bench of the LED display write port.
  Assumes short scan parameters and the host model driving the pins.
*/
`timescale 1ns/1ns
module led_display_write_port_test;
  localparam int SLOT = 80; // Long slot so the fill test outruns the drain
  localparam int BLANK = 4;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic write_strobe, mode_select, decimal_point_drive, write_ready;
  logic [7:0] input_bus, digit_drive, last;
  logic [6:0] led_bar_lines;
  int err_count = 0;
  int cmp_count = 0;
  int dark = 0;
  int lit = 0;
  logic [7:0] burst_w [8] = '{8'h81, 8'h02, 8'h84, 8'h08, 8'h90, 8'h20, 8'hC0, 8'h7F};

  led_host_model host (.core_clk(core_clk), .write_strobe(write_strobe),
    .mode_select(mode_select), .input_bus(input_bus));

  led_display_write_port #(.SLOT_CYCLES(SLOT), .BLANK_CYCLES(BLANK), .FIFO_DEPTH(16)) DUT (
    .core_clk(core_clk), .resetn(resetn), .write_strobe(write_strobe),
    .mode_select(mode_select), .input_bus(input_bus), .led_bar_lines(led_bar_lines),
    .decimal_point_drive(decimal_point_drive), .digit_drive(digit_drive),
    .write_ready(write_ready));

  // 50 ns period
  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Writes drain only in blanking, so allow ten slots
  task automatic settle();
    repeat (10 * SLOT) @(negedge core_clk);
  endtask

  // Wait for digit k to light, then compare its dp and segments
  task automatic see(input int k, input logic [7:0] exp);
    int n;
    n = 0;
    while (digit_drive !== (8'h01 << k) && n < 20 * SLOT) begin
      @(negedge core_clk);
      n++;
    end
    check("digit drive", 8'h01 << k, digit_drive);
    check("digit word", exp, {decimal_point_drive, led_bar_lines});
  endtask

  ////////////////////////////////////////////////////////////
  // At each slot change: one digit only, after a full dark span
  always @(negedge core_clk) begin
    if (digit_drive === 8'h00) dark++;
    else begin
      if (last !== digit_drive) begin
        check("one digit", 8'h01, 8'($onehot(digit_drive)));
        check("blank span", 8'h01, 8'(dark >= BLANK));
      end
      dark = 0;
    end
    last = digit_drive;
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (8) @(negedge core_clk);
    check("ready in reset", 8'h00, {7'h00, write_ready});
    check("digits in reset", 8'h00, digit_drive);
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(negedge core_clk);
    check("ready", 8'h01, {7'h00, write_ready});
    // Raw burst of eight words, slow and fast host mixed
    host.put(1'b1, 8'hB0, 0);
    for (int i = 0; i < 8; i++) host.put(1'b0, burst_w[i], i % 2);
    settle();
    for (int i = 0; i < 8; i++) see(i, burst_w[i]);
    // Single digit; the second RAM write must be ignored
    host.put(1'b1, 8'h33, 2);
    host.put(1'b0, 8'h7F, 0);
    host.put(1'b0, 8'h00, 0);
    settle();
    see(3, 8'h7F);
    see(4, burst_w[4]);
    // Hex then BCD font, bank A then bank B at digit 2
    host.put(1'b1, 8'h52, 0);
    host.put(1'b0, 8'h0A, 0);
    host.put(1'b1, 8'h5A, 0);
    host.put(1'b0, 8'h01, 0);
    settle();
    see(2, 8'h06);
    host.put(1'b1, 8'h52, 0);
    settle();
    see(2, 8'h77);
    host.put(1'b1, 8'h12, 0);
    settle();
    see(2, 8'h40);
    // Shutdown darkens everything, wake shows bank B digit 0
    host.put(1'b1, 8'h00, 0);
    settle();
    repeat (2 * SLOT) begin
      @(negedge core_clk);
      if (digit_drive !== 8'h00 || led_bar_lines !== 7'h00) lit++;
    end
    check("shutdown dark", 8'h00, 8'(lit));
    host.put(1'b1, 8'h10, 0);
    settle();
    see(0, 8'h3F);
    // Fill the buffer until refused, then drain
    n = 0;
    while (write_ready === 1'b1 && n < 80) begin
      host.put(1'b1, 8'h10, 0);
      // Look at the ready flag away from the edge that updates it
      @(negedge core_clk);
      n++;
    end
    check("refused", 8'h00, {7'h00, write_ready});
    n = 0;
    while (write_ready !== 1'b1 && n < 40 * SLOT) begin
      @(negedge core_clk);
      n++;
    end
    check("drained", 8'h01, {7'h00, write_ready});
    close_out();
  end
endmodule
